// ==== core/numeric_coprocessor_glue.sv ====
// Purpose: Glue between a host processor and its numeric coprocessor.
// Assumes: mclk_i is the double-rate clock; host bus signals are on mclk_i.
// Notes: Coprocessor status pins and system reset are synchronised.
`timescale 1ns/10ps
`default_nettype none
`include "copglue_params.svh"
module numeric_coprocessor_glue #(
  parameter bit SEP_RESET_EN = 1'b1
) (
  input  wire logic                   mclk_i,
  input  wire logic                   rstn_i,
  input  wire logic                   system_reset_in_i,
  input  wire copglue_pkg::cop_in_s   cop_pins_i,
  input  wire logic                   cop_ready_out_n_i,
  input  wire copglue_pkg::host_bus_s host_bus_i,
  output logic                        fault_irq_flag_o,
  output logic                        host_busy_n_o,
  output logic                        operand_request_n_o,
  output logic                        host_ready_n_o,
  output logic                        host_error_n_o,
  output logic                        channel_ready_n_o,
  output logic                        cop_reset_o,
  output logic                        status_enable_o,
  output logic                        cop_clk_phase_o,
  output logic                        wide_access_strobe_n_o,
  output logic                        wide_access_strobe_oe_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Synchronised inputs.
  // System reset passes the same filter, so a short glitch on the board line
  // cannot clear the fault flag or pulse the coprocessor reset.
  copglue_pkg::cop_in_s cop_q;
  logic                 sys_rst_q;

  pin_sync #(
    .W       (3),
    .RST_VAL (3'b110)
  ) u_cop_sync (
    .mclk_i (mclk_i),
    .rstn_i (rstn_i),
    .d_i    (cop_pins_i),
    .q_o    (cop_q)
  );

  pin_sync #(
    .W       (1),
    .RST_VAL (1'b1)
  ) u_rst_sync (
    .mclk_i (mclk_i),
    .rstn_i (rstn_i),
    .d_i    (system_reset_in_i),
    .q_o    (sys_rst_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Port decode and phase.
  logic clr_wr;
  logic rst_wr;
  logic phase_r;
  logic err_prev_r;
  logic err_edge;
  logic flag_clr;
  logic flag_r;
  logic seq_rst;
  logic seq_hold;
  logic ready_seen_r;

  assign clr_wr   = host_bus_i.io_wr && (host_bus_i.io_addr == `PORT_FLAG_CLR);
  assign rst_wr   = host_bus_i.io_wr && (host_bus_i.io_addr == `PORT_COP_RST)
                    && (host_bus_i.io_data == `COP_RST_DATA);
  assign err_edge = err_prev_r && !cop_q.error_n;
  assign flag_clr = clr_wr || !host_bus_i.irq_acknowledge_n || sys_rst_q;

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      phase_r <= 1'b0;
    end else begin
      phase_r <= ~phase_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fault flag. A new error edge wins over a clear in the same cycle.
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      err_prev_r <= 1'b1;
      flag_r     <= 1'b0;
    end else begin
      err_prev_r <= cop_q.error_n;
      if (err_edge) begin
        flag_r <= 1'b1;
      end else if (flag_clr) begin
        flag_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Host-facing status lines.
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      fault_irq_flag_o    <= 1'b0;
      host_busy_n_o       <= 1'b1;
      operand_request_n_o <= 1'b1;
    end else begin
      fault_irq_flag_o    <= flag_r;
      host_busy_n_o       <= cop_q.busy_n && !flag_r;
      // Request only once busy has dropped, so no transfer starts mid-command.
      operand_request_n_o <= !((cop_q.operand_request_n && cop_q.busy_n)
                               || (flag_r && cop_q.busy_n));
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      host_ready_n_o  <= 1'b1;
      status_enable_o <= 1'b1;
      cop_clk_phase_o <= 1'b0;
    end else begin
      host_ready_n_o  <= cop_ready_out_n_i;
      status_enable_o <= 1'b1;
      cop_clk_phase_o <= ~phase_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Coprocessor type recognition: error held low until the first ready.
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      ready_seen_r   <= 1'b0;
      host_error_n_o <= 1'b0;
    end else begin
      if (sys_rst_q) begin
        ready_seen_r <= 1'b0;
      end else if (!host_bus_i.ready_n) begin
        ready_seen_r <= 1'b1;
      end
      host_error_n_o <= ready_seen_r && !sys_rst_q && host_bus_i.ready_n ? 1'b1
                        : (!sys_rst_q && !host_bus_i.ready_n);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Separate reset sequence and channel-ready hold.
  cop_reset_seq u_seq (
    .mclk_i    (mclk_i),
    .rstn_i    (rstn_i),
    .start_i   (rst_wr && SEP_RESET_EN),
    .phase2_i  (phase_r),
    .cop_rst_o (seq_rst),
    .hold_o    (seq_hold)
  );

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      cop_reset_o       <= 1'b1;
      channel_ready_n_o <= 1'b1;
    end else begin
      cop_reset_o       <= sys_rst_q || (SEP_RESET_EN && seq_rst);
      // Holding ready also stalls refresh; the worst case is one full sequence.
      channel_ready_n_o <= !((rst_wr && SEP_RESET_EN) || seq_hold);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Forced wide access strobe for coprocessor I/O cycles.
  logic strobe_set;
  assign strobe_set = !host_bus_i.addr_latch_en_n && phase_r
                      && host_bus_i.top_address_bit && !host_bus_i.mem_io_select_n;

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      wide_access_strobe_n_o  <= 1'b1;
      wide_access_strobe_oe_o <= 1'b0;
    end else begin
      // Release while phase is high so it is gone before the next latch enable.
      wide_access_strobe_n_o  <= !(strobe_set
                                   || (!wide_access_strobe_n_o && !phase_r));
      wide_access_strobe_oe_o <= strobe_set
                                 || (!wide_access_strobe_n_o && !phase_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  a_flag_on_edge: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    err_edge |=> flag_r ##1 fault_irq_flag_o)
    else $error("error edge did not raise fault flag");
  a_flag_clears: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (flag_clr && !err_edge) |=> !flag_r ##1 !fault_irq_flag_o)
    else $error("fault flag not cleared");
  a_busy_stretch: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    flag_r |=> !host_busy_n_o)
    else $error("host busy not stretched by fault flag");
  a_req_after_busy: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    !operand_request_n_o |-> $past(cop_q.busy_n))
    else $error("operand request while coprocessor busy");
  a_req_on_flag: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (flag_r && cop_q.busy_n) |=> !operand_request_n_o)
    else $error("operand request missing after error");
  a_ready_delay: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    $fell(cop_ready_out_n_i) |=> !host_ready_n_o ##0 $past(host_ready_n_o))
    else $error("coprocessor ready not delayed by one clock");
  a_status_high: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    status_enable_o)
    else $error("status enable not high");
  a_sysrst_direct: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    sys_rst_q |=> cop_reset_o && !flag_r)
    else $error("system reset did not reach coprocessor");
  a_error_early: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (sys_rst_q ##1 (!sys_rst_q && host_bus_i.ready_n)) |=> !host_error_n_o)
    else $error("host error released before first ready");
  a_rst_holds: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (rst_wr && SEP_RESET_EN && !seq_hold) |=> !channel_ready_n_o [*8])
    else $error("reset port write not held off");
  a_strobe_decode: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    strobe_set |=> !wide_access_strobe_n_o && wide_access_strobe_oe_o)
    else $error("wide access strobe not forced");

  ////////////////////////////////////////////////////////////////////////////
  // Exact output checks, written from the rule equations rather than the logic.
  // Each output is one register behind its inputs, hence the sampled past terms.
  // A failure here usually means a term was dropped from an output equation.
  a_set_wins: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (err_edge && flag_clr) |=> flag_r)
    else $error("clear beat a new error edge");
  a_no_spurious: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (!flag_r && !err_edge) |=> !flag_r)
    else $error("fault flag set without an error edge");
  a_irq_tracks: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    fault_irq_flag_o == $past(flag_r))
    else $error("interrupt request does not follow fault flag");
  a_busy_exact: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    !host_busy_n_o == $past(!cop_q.busy_n || flag_r))
    else $error("host busy is not coprocessor busy or flag");
  a_req_exact: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    !operand_request_n_o == $past(cop_q.busy_n && (cop_q.operand_request_n || flag_r)))
    else $error("operand request equation broken");
  a_req_blocked: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    !cop_q.busy_n |=> operand_request_n_o)
    else $error("operand request raised during busy");
  a_ready_follows: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    host_ready_n_o == $past(cop_ready_out_n_i))
    else $error("host ready is not coprocessor ready one clock late");
  a_error_on_reset: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    sys_rst_q |=> !host_error_n_o)
    else $error("host error not forced low by system reset");
  a_error_after_ready: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (!sys_rst_q && !host_bus_i.ready_n) |=> host_error_n_o)
    else $error("host error still low after host ready");
  a_sysrst_flag: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (sys_rst_q && !err_edge) |=> !flag_r)
    else $error("system reset did not clear fault flag");
  a_hold_on_seq: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    seq_hold |=> !channel_ready_n_o)
    else $error("channel ready released during reset sequence");
  a_ready_free: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (!seq_hold && !(rst_wr && SEP_RESET_EN)) |=> channel_ready_n_o)
    else $error("channel ready held with no reset sequence");
  a_nonzero_ignored: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (host_bus_i.io_wr && (host_bus_i.io_addr == `PORT_COP_RST) && !rst_wr && !seq_hold)
      |=> channel_ready_n_o)
    else $error("nonzero reset port write started a sequence");
  a_seq_to_pin: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    seq_rst |=> cop_reset_o)
    else $error("sequence reset did not reach coprocessor");
  a_strobe_hold: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (!wide_access_strobe_n_o && !phase_r) |=> !wide_access_strobe_n_o)
    else $error("wide access strobe dropped in low phase");
  a_strobe_release: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (!wide_access_strobe_n_o && phase_r && !strobe_set) |=> wide_access_strobe_n_o)
    else $error("wide access strobe not released in high phase");
  a_strobe_oe: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    wide_access_strobe_oe_o == !wide_access_strobe_n_o)
    else $error("strobe drive enable does not match strobe");
  a_phase_copy: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    cop_clk_phase_o == phase_r)
    else $error("coprocessor phase differs from host phase");
endmodule // numeric_coprocessor_glue
`default_nettype wire

// ==== core/copglue_params.svh ====
// Purpose: Shared constants for the coprocessor glue.
// Assumes: The block clock is the double-rate processor clock.
// Notes: Cycle figures are double-rate clock cycles.
`ifndef COPGLUE_PARAMS_SVH
`define COPGLUE_PARAMS_SVH

`define CLK_PERIOD_NS      100
`define PORT_FLAG_CLR      16'h00F0
`define PORT_COP_RST       16'h00F1
`define COP_RST_DATA       8'h00
`define COP_RST_MIN_CYC    78
`define COP_RST_HOLD_CYC   128
`define COP_INIT_MIN_CYC   50
`define COP_INIT_HOLD_CYC  64
`define SEQ_CNT_W          8
`define PHASE2_VAL         1'b1

`endif

// ==== core/copglue_pkg.sv ====
// Purpose: Types shared by the coprocessor glue modules.
// Assumes: Nothing beyond the constants header.
// Notes: Pin groups travel as packed structs.
package copglue_pkg;

  typedef struct packed {
    logic error_n;
    logic busy_n;
    logic operand_request_n;
  } cop_in_s;

  typedef struct packed {
    logic        io_wr;
    logic [15:0] io_addr;
    logic [7:0]  io_data;
    logic        irq_acknowledge_n;
    logic        top_address_bit;
    logic        mem_io_select_n;
    logic        addr_latch_en_n;
    logic        ready_n;
  } host_bus_s;

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_RESET,
    SEQ_ALIGN,
    SEQ_INIT
  } seq_state_e;

endpackage

// ==== core/pin_sync.sv ====
// Purpose: Three-stage synchroniser with agreement filter, one lane per bit.
// Assumes: Inputs are asynchronous to mclk_i.
// Notes: The first stage feeds only the second.
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter int          W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         mclk_i,
  input  wire logic         rstn_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_lane
      logic s1_r;
      logic s2_r;
      logic s3_r;
      logic q_r;
      always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
          s1_r <= RST_VAL[g];
          s2_r <= RST_VAL[g];
          s3_r <= RST_VAL[g];
          q_r  <= RST_VAL[g];
        end else begin
          s1_r <= d_i[g];
          s2_r <= s1_r;
          s3_r <= s2_r;
          if (s2_r == s3_r) begin
            q_r <= s3_r;
          end
        end
      end
      assign q_o[g] = q_r;
    end
  endgenerate
endmodule // pin_sync
`default_nettype wire

// ==== core/cop_reset_seq.sv ====
// Purpose: Separate coprocessor reset sequence with ready hold-off.
// Assumes: phase2_i marks the second phase of the double-rate clock.
// Notes: A start during a running sequence is ignored.
`timescale 1ns/10ps
`default_nettype none
`include "copglue_params.svh"
module cop_reset_seq (
  input  wire logic mclk_i,
  input  wire logic rstn_i,
  input  wire logic start_i,
  input  wire logic phase2_i,
  output logic      cop_rst_o,
  output logic      hold_o
);
  copglue_pkg::seq_state_e state_r;
  logic [`SEQ_CNT_W-1:0]   cnt_r;
  logic [`SEQ_CNT_W-1:0]   rst_len_r;
  logic [`SEQ_CNT_W-1:0]   init_len_r;

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      state_r <= copglue_pkg::SEQ_IDLE;
      cnt_r   <= '0;
    end else begin
      unique case (state_r)
        copglue_pkg::SEQ_IDLE: begin
          cnt_r <= '0;
          if (start_i) begin
            state_r <= copglue_pkg::SEQ_RESET;
          end
        end
        copglue_pkg::SEQ_RESET: begin
          cnt_r <= cnt_r + 1'b1;
          if (cnt_r == `SEQ_CNT_W'(`COP_RST_HOLD_CYC - 1)) begin
            state_r <= copglue_pkg::SEQ_ALIGN;
          end
        end
        copglue_pkg::SEQ_ALIGN: begin
          cnt_r <= '0;
          if (phase2_i == `PHASE2_VAL) begin
            state_r <= copglue_pkg::SEQ_INIT;
          end
        end
        copglue_pkg::SEQ_INIT: begin
          cnt_r <= cnt_r + 1'b1;
          if (cnt_r == `SEQ_CNT_W'(`COP_INIT_HOLD_CYC - 1)) begin
            state_r <= copglue_pkg::SEQ_IDLE;
          end
        end
      endcase
    end
  end

  assign cop_rst_o = (state_r == copglue_pkg::SEQ_RESET) || (state_r == copglue_pkg::SEQ_ALIGN);
  assign hold_o    = (state_r != copglue_pkg::SEQ_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // Helper counters measure the reset and init widths for the checks.
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      rst_len_r  <= '0;
      init_len_r <= '0;
    end else begin
      rst_len_r  <= cop_rst_o ? rst_len_r + 1'b1 : '0;
      init_len_r <= (hold_o && !cop_rst_o) ? init_len_r + 1'b1 : '0;
    end
  end

  a_rst_width: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    $fell(cop_rst_o) |-> $past(rst_len_r) >= `SEQ_CNT_W'(`COP_RST_MIN_CYC - 1))
    else $error("coprocessor reset shorter than minimum");
  a_rst_phase: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    $fell(cop_rst_o) |-> $past(phase2_i) == `PHASE2_VAL)
    else $error("coprocessor reset released outside phase two");
  a_init_hold: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    $fell(hold_o) |-> $past(init_len_r) >= `SEQ_CNT_W'(`COP_INIT_MIN_CYC - 1))
    else $error("instruction hold-off too short after reset");
endmodule // cop_reset_seq
`default_nettype wire

// ==== tb/cop_model.sv ====
// Purpose: Behavioural numeric coprocessor at the far side of the glue.
// Assumes: The bench sets the command inputs on the falling clock edge.
// Notes: Status pins go idle while the coprocessor is held in reset.
`timescale 1ns/10ps
`default_nettype none
module cop_model (
  input  wire logic                mclk_i,
  input  wire logic                cop_reset_i,
  input  wire logic                err_i,
  input  wire logic                busy_i,
  input  wire logic                req_i,
  input  wire logic                rdy_i,
  output var copglue_pkg::cop_in_s pins_o,
  output logic                     ready_out_n_o
);
  //////////////////////////////////////////////////////////////////////////////
  // Pins move just after the rising edge, as a real part's outputs would.
  always_ff @(posedge mclk_i) begin
    if (cop_reset_i) begin
      pins_o        <= {1'b1, 1'b1, 1'b0};
      ready_out_n_o <= 1'b1;
    end else begin
      pins_o.error_n <= ~err_i;
      pins_o.busy_n  <= ~busy_i;
      pins_o.operand_request_n   <= req_i;
      ready_out_n_o  <= ~rdy_i;
    end
  end
endmodule // cop_model
`default_nettype wire

// ==== tb/tb_numeric_coprocessor_glue.sv ====
// Purpose: Self-checking bench for the coprocessor glue.
// Assumes: Inputs change on the falling edge; outputs are read there.
// Notes: Waits are bounded; pins pass a synchroniser before use.
`timescale 1ns/10ps
`default_nettype none
module tb_numeric_coprocessor_glue;
  logic                   mclk_i;
  logic                   rstn_i;
  logic                   sys_rst;
  logic                   err_c, busy_c, req_c, rdy_c;
  copglue_pkg::cop_in_s   pins;
  logic                   rdy_n;
  copglue_pkg::host_bus_s hb;
  logic                   flag, busy_n, req_n, hrdy_n, herr_n, chrdy_n;
  logic                   crst, status_enable, phase, strb_n, strb_oe;
  int                     mismatches;
  int                     num_checks;
  //////////////////////////////////////////////////////////////////////////////
  numeric_coprocessor_glue u_numeric_coprocessor_glue (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .system_reset_in_i(sys_rst),
    .cop_pins_i(pins), .cop_ready_out_n_i(rdy_n), .host_bus_i(hb),
    .fault_irq_flag_o(flag), .host_busy_n_o(busy_n),
    .operand_request_n_o(req_n), .host_ready_n_o(hrdy_n),
    .host_error_n_o(herr_n), .channel_ready_n_o(chrdy_n),
    .cop_reset_o(crst), .status_enable_o(status_enable), .cop_clk_phase_o(phase),
    .wide_access_strobe_n_o(strb_n), .wide_access_strobe_oe_o(strb_oe));
  cop_model u_cop_model (
    .mclk_i(mclk_i), .cop_reset_i(crst), .err_i(err_c), .busy_i(busy_c),
    .req_i(req_c), .rdy_i(rdy_c), .pins_o(pins), .ready_out_n_o(rdy_n));
  initial mclk_i = 1'b0;
  always #50 mclk_i = ~mclk_i;
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic got, input logic exp, input string what);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s got %b", $time, what, got);
    end
  endtask
  task automatic chk_min(input int got, input int lo, input string what);
    num_checks++;
    if (got < lo) begin
      mismatches++;
      $display("mismatch at %0t: %s only %0d", $time, what, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk_i);
  endtask
  task automatic io_write(input logic [15:0] a, input logic [7:0] d);
    hb.io_wr = 1'b1;
    hb.io_addr = a;
    hb.io_data = d;
    cyc(1);
    hb.io_wr = 1'b0;
  endtask
  task automatic wait_cop_free;
    int i;
    for (i = 0; i < 400 && crst !== 1'b0; i++) cyc(1);
  endtask
  task automatic host_ready_pulse;
    chk(herr_n, 1'b0, "type error held");
    hb.ready_n = 1'b0;
    cyc(1);
    hb.ready_n = 1'b1;
    cyc(2);
    chk(herr_n, 1'b1, "type error released");
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_boot;
    logic p;
    chk(status_enable, 1'b1, "status enable");
    p = phase;
    cyc(1);
    chk(phase, ~p, "phase toggle");
    host_ready_pulse();
    wait_cop_free();
    $display("t_boot done");
  endtask
  task automatic t_ready;
    rdy_c = 1'b1;
    cyc(1);
    chk(hrdy_n, 1'b1, "ready early");
    cyc(1);
    chk(hrdy_n, 1'b0, "ready delayed");
    rdy_c = 1'b0;
    cyc(1);
    chk(hrdy_n, 1'b0, "ready held one");
    cyc(1);
    chk(hrdy_n, 1'b1, "ready released");
    $display("t_ready done");
  endtask
  task automatic t_strobe;
    hb.addr_latch_en_n = 1'b0;
    hb.mem_io_select_n = 1'b0;
    cyc(3);
    chk(strb_n, 1'b1, "no strobe low half");
    hb.top_address_bit = 1'b1;
    cyc(3);
    chk(strb_n, 1'b0, "strobe forced");
    chk(strb_oe, 1'b1, "strobe driven");
    hb.addr_latch_en_n = 1'b1;
    hb.top_address_bit = 1'b0;
    cyc(4);
    chk(strb_n, 1'b1, "strobe removed");
    chk(strb_oe, 1'b0, "strobe released");
    $display("t_strobe done");
  endtask
  task automatic t_req;
    int i;
    busy_c = 1'b1;
    req_c = 1'b1;
    cyc(10);
    chk(req_n, 1'b1, "request while busy");
    chk(busy_n, 1'b0, "busy passed");
    busy_c = 1'b0;
    for (i = 0; i < 10 && req_n !== 1'b0; i++) cyc(1);
    chk(req_n, 1'b0, "request after busy");
    req_c = 1'b0;
    for (i = 0; i < 10 && req_n !== 1'b1; i++) cyc(1);
    chk(req_n, 1'b1, "request dropped");
    $display("t_req done");
  endtask
  // Each pass raises an error, then clears it by one of the three causes.
  task automatic t_flag;
    int i;
    int k;
    for (k = 0; k < 3; k++) begin
      err_c = 1'b1;
      for (i = 0; i < 12 && flag !== 1'b1; i++) cyc(1);
      chk(flag, 1'b1, "flag set");
      chk(busy_n, 1'b0, "busy stretched");
      chk(req_n, 1'b0, "request after error");
      err_c = 1'b0;
      cyc(8);
      chk(flag, 1'b1, "flag sticky");
      if (k == 0) begin
        io_write(16'h00F0, 8'h00);
      end else if (k == 1) begin
        hb.irq_acknowledge_n = 1'b0;
        cyc(1);
        hb.irq_acknowledge_n = 1'b1;
      end else begin
        sys_rst = 1'b1;
        cyc(8);
        chk(crst, 1'b1, "system reset to coprocessor");
        sys_rst = 1'b0;
      end
      for (i = 0; i < 10 && flag !== 1'b0; i++) cyc(1);
      chk(flag, 1'b0, "flag cleared");
      chk(busy_n, 1'b1, "busy released");
    end
    // The synchronised system reset outlasts the pin by several clocks; the
    // first ready only counts once it is gone, so wait for that first.
    wait_cop_free();
    host_ready_pulse();
    $display("t_flag done");
  endtask
  task automatic t_coprst;
    int i;
    int n;
    io_write(16'h00F1, 8'h01);
    cyc(3);
    chk(chrdy_n, 1'b1, "nonzero data ignored");
    io_write(16'h00F1, 8'h00);
    chk(chrdy_n, 1'b0, "cycle held");
    for (i = 0; i < 4 && crst !== 1'b1; i++) cyc(1);
    chk(crst, 1'b1, "coprocessor reset");
    for (n = 0; n < 300 && crst === 1'b1; n++) cyc(1);
    chk_min(n, 78, "reset width");
    chk(chrdy_n, 1'b0, "held past reset");
    for (n = 0; n < 300 && chrdy_n === 1'b0; n++) cyc(1);
    chk_min(n, 50, "init gap");
    chk(chrdy_n, 1'b1, "cycle released");
    $display("t_coprst done");
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // The full run needs about 350 cycles; the limit leaves ample margin.
  initial begin
    repeat (5000) @(posedge mclk_i);
    mismatches++;
    final_report();
  end
  initial begin
    mismatches = 0;
    num_checks = 0;
    rstn_i = 1'b0;
    sys_rst = 1'b0;
    {err_c, busy_c, req_c, rdy_c} = 4'h0;
    hb = {1'b0, 16'h0000, 8'h00, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
    cyc(20);
    rstn_i = 1'b1;
    cyc(8);
    t_boot();
    t_ready();
    t_strobe();
    t_req();
    t_flag();
    t_coprst();
    final_report();
  end
endmodule // tb_numeric_coprocessor_glue
`default_nettype wire
